/* core/sst_pkg.sv */
// Package of constants and types for the switch telegram framer
package sst_pkg;
	localparam int unsigned ID_POS = 2;
	localparam int unsigned CNT_POS = 6;
	localparam int unsigned CMD_POS = 10;
	localparam int unsigned HDR_LEN = 2;
	localparam logic [7:0] CMD_PUSH = 8'h69;
	localparam logic [7:0] DATA_ENERGY_BAR = 8'h10;
	localparam logic [31:0] CNT_RESET = 32'h0000_0000;
	localparam int unsigned REPEATS = 3;
	localparam int unsigned FIFO_DEPTH = 4;
	localparam int unsigned MIX_ROUNDS = 8;
	// Arbitrary neutral identity value
	localparam logic [31:0] SENDER_ID_DEFAULT = 32'h1234_5678;
	localparam logic [15:0] HDR_BYTES = 16'h0000;
	typedef enum logic [2:0] {
		SST_IDLE,
		SST_SIGN,
		SST_SEND,
		SST_GAP
	} sst_state_t;
endpackage : sst_pkg

/* core/sst_byte_if.sv */
// Byte stream interface between framer and FIFO
`timescale 1ns/1ns
interface sst_byte_if;
	logic valid;
	logic ready;
	logic [7:0] data;
	logic last;
	modport src (output valid, output data, output last, input ready);
	modport snk (input valid, input data, input last, output ready);
endinterface : sst_byte_if

/* core/sst_fifo.sv */
// Small valid/ready FIFO for the outgoing byte stream
`timescale 1ns/1ns
module sst_fifo #(
	parameter int unsigned WIDTH = 9,
	parameter int unsigned DEPTH = sst_pkg::FIFO_DEPTH
) (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_in_valid,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_in_ready,
	output logic o_out_valid,
	output logic [WIDTH-1:0] o_out_data,
	input wire logic i_out_ready
);
	localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	initial begin
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
			$error("sst_fifo DEPTH must be a power of two >= 2");
	end
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0] wr_q;
	logic [AW:0] rd_q;
	wire full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
	wire empty = (wr_q == rd_q);
	wire push = i_in_valid && !full;
	wire pop = i_out_ready && !empty;
	assign o_in_ready = !full;
	assign o_out_valid = !empty;
	assign o_out_data = mem_q[rd_q[AW-1:0]];
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (push)
				wr_q <= wr_q + 1'b1;
			if (pop)
				rd_q <= rd_q + 1'b1;
		end
	end
	always_ff @(posedge i_mclk) begin
		if (push)
			mem_q[wr_q[AW-1:0]] <= i_in_data;
	end
endmodule : sst_fifo

/* core/sst_framer.sv */
// Telegram payload framer with counter, signature and repeats
`timescale 1ns/1ns
// What this block does
// - Sender identifier goes in payload bytes 2 to 5, low byte first.
// - Sequence counter goes in payload bytes 6 to 9, low byte first.
// - Command byte sits at byte 10, optionally followed by a data byte.
// - Button push is command 0x69; data 0x10 means energy bar pressed.
// - A 32-bit signature fills the last four bytes of each telegram.
// - Signature is built from secret key, payload and full counter.
// - Counter advances once per user action, after the last of its copies is sent.
// - Payload bytes go out in plain text, never encrypted.
// - Counter in the signature makes each user action's signature differ; its copies share one.
// - Each user action sends several redundant copies of the telegram.
module sst_framer #(
	parameter logic [31:0] SENDER_ID = sst_pkg::SENDER_ID_DEFAULT,
	parameter int unsigned REPEATS = sst_pkg::REPEATS,
	parameter int unsigned DEPTH = sst_pkg::FIFO_DEPTH
) (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic [127:0] i_key,
	input wire logic i_act_valid,
	input wire logic [7:0] i_act_cmd,
	input wire logic i_act_has_data,
	input wire logic [7:0] i_act_data,
	output logic o_act_ready,
	output logic o_byte_valid,
	output logic [7:0] o_byte_data,
	output logic o_byte_last,
	input wire logic i_byte_ready,
	output logic [31:0] o_counter
);
	initial begin
		if (REPEATS < 1 || REPEATS > 15)
			$error("sst_framer REPEATS must be 1..15");
	end
	////////////////////////////////////////////////////////////////////////
	// Action capture and counter
	sst_pkg::sst_state_t state_q;
	sst_pkg::sst_state_t state_d;
	logic [31:0] cnt_q;
	logic [7:0] cmd_q;
	logic [7:0] dat_q;
	logic has_dat_q;
	logic [3:0] rep_q;
	logic [3:0] idx_q;
	logic [3:0] rnd_q;
	logic [31:0] mac_q;
	logic [4:0] len_w;
	wire idle = (state_q == sst_pkg::SST_IDLE);
	wire take = idle && i_act_valid;
	assign o_act_ready = idle;
	assign o_counter = cnt_q;
	// Header, id, counter, command, optional data, signature
	assign len_w = has_dat_q ? 5'd16 : 5'd15;
	////////////////////////////////////////////////////////////////////////
	// Signature mixer over key, payload and counter
	wire [31:0] k_word = i_key[rnd_q[1:0]*32 +: 32];
	wire [31:0] mix_in = {dat_q, cmd_q, 15'h0000, has_dat_q} ^ SENDER_ID;
	wire [31:0] mix_a = mac_q ^ k_word ^ cnt_q;
	wire [31:0] mix_b = {mix_a[24:0], mix_a[31:25]} + (mix_in ^ k_word);
	wire [31:0] mix_n = mix_b ^ {mix_b[12:0], mix_b[31:13]};
	wire sign_done = (rnd_q == 4'(sst_pkg::MIX_ROUNDS - 1));
	////////////////////////////////////////////////////////////////////////
	// Byte selection, plain text
	logic [7:0] byte_w;
	always_comb begin
		byte_w = 8'h00;
		if (idx_q < 4'(sst_pkg::ID_POS))
			byte_w = sst_pkg::HDR_BYTES[idx_q[0]*8 +: 8];
		else if (idx_q < 4'(sst_pkg::CNT_POS))
			byte_w = SENDER_ID[(idx_q - 4'd2)*8 +: 8];
		else if (idx_q < 4'(sst_pkg::CMD_POS))
			byte_w = cnt_q[(idx_q - 4'd6)*8 +: 8];
		else if (idx_q == 4'(sst_pkg::CMD_POS))
			byte_w = cmd_q;
		else if (has_dat_q && idx_q == 4'd11)
			byte_w = dat_q;
		else
			byte_w = mac_q[({1'b0, idx_q} + 5'd4 - len_w)*8 +: 8];
	end
	wire send = (state_q == sst_pkg::SST_SEND);
	wire last_w = ({1'b0, idx_q} == len_w - 5'd1);
	wire f_ready;
	wire push = send && f_ready;
	////////////////////////////////////////////////////////////////////////
	// Control
	always_comb begin
		state_d = state_q;
		case (state_q)
			sst_pkg::SST_IDLE:
				if (i_act_valid)
					state_d = sst_pkg::SST_SIGN;
			sst_pkg::SST_SIGN:
				if (sign_done)
					state_d = sst_pkg::SST_SEND;
			sst_pkg::SST_SEND:
				if (push && last_w)
					state_d = sst_pkg::SST_GAP;
			sst_pkg::SST_GAP:
				if (rep_q == 4'(REPEATS - 1))
					state_d = sst_pkg::SST_IDLE;
				else
					state_d = sst_pkg::SST_SEND;
			default:
				state_d = sst_pkg::SST_IDLE;
		endcase
	end
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			state_q <= sst_pkg::SST_IDLE;
			cnt_q <= sst_pkg::CNT_RESET;
			cmd_q <= 8'h00;
			dat_q <= 8'h00;
			has_dat_q <= 1'b0;
			rep_q <= 4'h0;
			idx_q <= 4'h0;
			rnd_q <= 4'h0;
			mac_q <= 32'h0000_0000;
		end else begin
			state_q <= state_d;
			if (take) begin
				cmd_q <= i_act_cmd;
				dat_q <= i_act_data;
				has_dat_q <= i_act_has_data;
				rep_q <= 4'h0;
				idx_q <= 4'h0;
				rnd_q <= 4'h0;
				mac_q <= 32'h0000_0000;
			end
			if (state_q == sst_pkg::SST_SIGN) begin
				mac_q <= mix_n;
				rnd_q <= rnd_q + 4'h1;
			end
			if (push)
				idx_q <= last_w ? 4'h0 : idx_q + 4'h1;
			if (state_q == sst_pkg::SST_GAP) begin
				rep_q <= rep_q + 4'h1;
				if (rep_q == 4'(REPEATS - 1))
					cnt_q <= cnt_q + 32'h1;
			end
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Output FIFO
	sst_byte_if fifo_in ();
	assign fifo_in.valid = send;
	assign fifo_in.data = byte_w;
	assign fifo_in.last = last_w;
	assign f_ready = fifo_in.ready;
	sst_fifo #(.WIDTH(9), .DEPTH(DEPTH)) u_fifo (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_in_valid(fifo_in.valid),
		.i_in_data({fifo_in.last, fifo_in.data}),
		.o_in_ready(fifo_in.ready),
		.o_out_valid(o_byte_valid),
		.o_out_data({o_byte_last, o_byte_data}),
		.i_out_ready(i_byte_ready)
	);
endmodule : sst_framer

/* tb/sst_framer_monitor.sv */
// Checker for the switch telegram framer ports
`timescale 1ns/1ns
module sst_framer_monitor #(
	parameter logic [31:0] SENDER_ID = sst_pkg::SENDER_ID_DEFAULT
) (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_act_valid,
	input wire logic [7:0] i_act_cmd,
	input wire logic i_act_has_data,
	input wire logic o_act_ready,
	input wire logic o_byte_valid,
	input wire logic [7:0] o_byte_data,
	input wire logic o_byte_last,
	input wire logic i_byte_ready,
	input wire logic [31:0] o_counter
);
default clocking @(posedge i_mclk); endclocking
default disable iff (i_rst);
logic [3:0] idx_q;
wire acc = o_byte_valid & i_byte_ready;
// Position of the next byte within a copy
always_ff @(posedge i_mclk) begin
	if (i_rst) idx_q <= 4'h0;
	else if (acc) idx_q <= o_byte_last ? 4'h0 : idx_q + 4'h1;
end
property p_rst; $past(i_rst) |-> o_act_ready && !o_byte_valid
	&& o_counter == 32'h0; endproperty
a_rst: assert property (p_rst) else $error("reset state");
property p_step; $changed(o_counter) && !$past(i_rst)
	|-> o_counter == $past(o_counter) + 32'h1; endproperty
a_step: assert property (p_step) else $error("count step");
property p_lat; i_act_valid && o_act_ready |-> ##10 o_byte_valid;
endproperty
a_lat: assert property (p_lat) else $error("late byte");
property p_hold; o_byte_valid && !i_byte_ready |=> o_byte_valid
	&& $stable(o_byte_data) && $stable(o_byte_last); endproperty
a_hold: assert property (p_hold) else $error("byte moved");
property p_id; acc && idx_q inside {[2:5]}
	|-> o_byte_data == SENDER_ID[8*(idx_q-2)+:8]; endproperty
a_id: assert property (p_id) else $error("id byte");
property p_cnt; acc && idx_q inside {[6:9]}
	|-> o_byte_data == o_counter[8*(idx_q-6)+:8]; endproperty
a_cnt: assert property (p_cnt) else $error("count byte");
property p_cmd; acc && idx_q == 4'ha |-> o_byte_data == i_act_cmd;
endproperty
a_cmd: assert property (p_cmd) else $error("cmd byte");
property p_len; acc && o_byte_last
	|-> idx_q == (i_act_has_data ? 4'hf : 4'he); endproperty
a_len: assert property (p_len) else $error("length");
endmodule : sst_framer_monitor

/* tb/sst_sink.sv */
// Receiver model that accepts bytes promptly or with stalls
`timescale 1ns/1ns
module sst_sink (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_slow,
	output logic o_ready
);
logic [7:0] lf_q;
always_ff @(posedge i_mclk) begin
	if (i_rst) lf_q <= 8'h5a;
	else lf_q <= {lf_q[6:0], lf_q[7] ^ lf_q[5] ^ lf_q[4] ^ lf_q[3]};
end
assign o_ready = i_slow ? lf_q[0] & lf_q[2] : 1'b1;
endmodule : sst_sink

/* tb/testbench.sv */
// Bench for the switch telegram framer
`timescale 1ns/1ns
bind sst_framer sst_framer_monitor #(.SENDER_ID(SENDER_ID)) i_mon(.i_mclk,
	.i_rst, .i_act_valid, .i_act_cmd, .i_act_has_data, .o_act_ready,
	.o_byte_valid, .o_byte_data, .o_byte_last, .i_byte_ready, .o_counter);
module testbench;
logic clk = 0, rst = 1, av = 0, hd = 0, slow = 0, rdy, v, l, ar;
logic [7:0] cmd = 0, dat = 0, bd;
logic [7:0] fr [3][16];
logic [31:0] cnt, r, sig, prev, ms, pc, seed = 32'he270;
logic [127:0] key = 128'h0f1e2d3c;
int num_errors = 0, n_tests = 0, cyc = 0, nf = 0, bi = 0, fl [3];
always #2 clk = ~clk;
sst_framer i_dut(.i_mclk(clk), .i_rst(rst), .i_key(key),
	.i_act_valid(av), .i_act_cmd(cmd), .i_act_has_data(hd),
	.i_act_data(dat), .o_act_ready(ar), .o_byte_valid(v), .o_byte_data(bd),
	.o_byte_last(l), .i_byte_ready(rdy), .o_counter(cnt));
sst_sink i_snk(.i_mclk(clk), .i_rst(rst), .i_slow(slow), .o_ready(rdy));
function logic [31:0] nxt();
	seed ^= seed << 13;
	seed ^= seed >> 17;
	seed ^= seed << 5;
	return seed;
endfunction : nxt
function automatic logic [7:0] exp_b(int i, logic [31:0] k);
	logic [31:0] id = sst_pkg::SENDER_ID_DEFAULT;
	if (i < 2) return 8'h00;
	if (i < 6) return id[8*(i-2)+:8];
	if (i < 10) return k[8*(i-6)+:8];
	return (i == 10) ? cmd : dat;
endfunction : exp_b
// Receiver side recomputation of the keyed signature
function automatic logic [31:0] sig_ref(logic [31:0] c);
	logic [31:0] m, k, x, y, w;
	m = 32'h0000_0000;
	w = {dat, cmd, 15'h0000, hd} ^ sst_pkg::SENDER_ID_DEFAULT;
	for (int n = 0; n < sst_pkg::MIX_ROUNDS; n++) begin
		k = key[(n % 4)*32 +: 32];
		x = m ^ k ^ c;
		y = {x[24:0], x[31:25]} + (w ^ k);
		m = y ^ {y[12:0], y[31:13]};
	end
	return m;
endfunction : sig_ref
task check(input logic [31:0] got, input logic [31:0] exp);
	n_tests++;
	if (got !== exp) begin
		num_errors++;
		$display("Error %0t got %h exp %h", $time, got, exp);
	end
endtask : check
task conclude;
	if (num_errors == 0 && n_tests > 0) $display("DONE - PASS");
	else $display("DONE - FAIL");
	$finish;
endtask : conclude
always @(posedge clk) begin
	cyc++;
	if (cyc > 20000) begin
		num_errors++;
		conclude();
	end
	if (v && rdy) begin
		fr[nf][bi] = bd;
		bi++;
		if (l) begin
			fl[nf] = bi;
			bi = 0;
			nf++;
		end
	end
end
initial begin
	repeat (12) @(posedge clk);
	#1 rst = 0;
	for (int a = 0; a < 8; a++) begin
		r = nxt();
		// Two identical energy-bar pushes first
		cmd = (a < 2) ? sst_pkg::CMD_PUSH : r[7:0];
		dat = (a < 2) ? sst_pkg::DATA_ENERGY_BAR : r[15:8];
		hd = (a < 2) | r[16];
		slow = r[17];
		av = 1;
		nf = 0;
		do @(posedge clk); while (!ar);
		#1 av = 0;
		wait (nf == 3);
		ms = sig_ref(a);
		for (int f = 0; f < 3; f++) begin
			check(fl[f], hd ? 16 : 15);
			for (int i = 0; i < fl[f]; i++)
				check(fr[f][i], i < fl[f] - 4 ? exp_b(i, a) :
					ms[8*(i-fl[f]+4)+:8]);
		end
		r = {fr[0][9], fr[0][8], fr[0][7], fr[0][6]};
		if (a > 0) check(r > pc, 1);
		pc = r;
		sig = {fr[0][fl[0]-1], fr[0][fl[0]-2], fr[0][fl[0]-3], fr[0][fl[0]-4]};
		if (a == 1) check(sig == prev, 0);
		prev = sig;
		wait (ar);
		@(posedge clk);
		#1 check(cnt, a + 1);
	end
	conclude();
end
endmodule : testbench
